//--- common/fault_consts.svh
// What this block does
// - Every fault falls into one of four levels: system, error, warning, sensor.
// - The reset pin leaves a system fault and its indication untouched.
// - Only a power-on reset clears a system fault.
// - An error latches and clears after reset once its cause is gone.
// - Suspend asserts while unreferenced, injecting pulses, or after an algorithm failure.
// - Suspend follows its causes and drops as soon as none remain.
// - Warning never latches and drops as soon as its cause goes.
// - In advanced error mode a sensor failure asserts warning.
// - A sensor failure becomes an error only if that sensor has an active role.
// - Every unit with the failed sensor allocated reports the failure.
// - Input count is the raw encoder count accumulated since referencing.
// - Total compensation is encoder plus workpiece plus structure terms.
// - In linear encoder mode air temperature reads a fixed default.
// - Configuration mode keeps the error output asserted.
// - Suspend and warning outputs are active low.
// - Up to four parameter tables; the selection reads as 1 to 4.
//
// Purpose: constants for the fault status manager
// Assumes: 100 MHz clk
// Notes:   temperatures are in tenths of a degree Celsius
`ifndef FAULT_CONSTS_SVH
`define FAULT_CONSTS_SVH
`define CLK_MHZ             100
`define DEBOUNCE_TIME_US    1000
`define DEBOUNCE_CYCLES     (`DEBOUNCE_TIME_US * `CLK_MHZ)
`define SENSOR_COUNT        4
`define ERR_SRC_COUNT       4
`define COUNT_W             32
`define COMP_W              24
`define TEMP_W              16
`define AIR_DEFAULT_DECI_C  16'h00c8
`define TABLE_COUNT         3'h4
`define TABLE_FIRST         3'h1
`define SEV_CODE_NONE       3'h0
`endif

//--- common/fault_if.sv
// Purpose: carries clear requests and counts between the fault core and its helpers
// Assumes: one clock domain
// Notes:   none
interface fault_if;
    import fault_pkg::*;
    logic   clear_pulse;
    count_t raw_count;
    count_t out_count;
    count_t comp_sum;

    modport deb  (output clear_pulse);
    modport cnt  (output raw_count, output out_count, output comp_sum);
    modport core (input clear_pulse, input raw_count,
                  input out_count, input comp_sum);
endinterface

//--- common/fault_pkg.sv
// Purpose: shared types of the fault status manager
// Assumes: fault_consts.svh defines the widths
// Notes:   severity order follows enum order
`include "fault_consts.svh"
package fault_pkg;
    typedef enum logic [2:0] {
        SEV_NONE,
        SEV_SYSTEM,
        SEV_ERROR,
        SEV_WARNING,
        SEV_SENSOR
    } sev_t;

    typedef enum logic [1:0] {
        DB_IDLE,
        DB_LOW_WAIT,
        DB_HELD
    } db_state_t;

    typedef logic signed [`COUNT_W-1:0] count_t;
    typedef logic signed [`COMP_W-1:0]  comp_t;
    typedef logic signed [`TEMP_W-1:0]  temp_t;
    typedef logic [`SENSOR_COUNT-1:0]   sensor_vec_t;
endpackage

//--- dv/aux_ctrl_model.sv
// Purpose: machine controller side of the auxiliary reset line
// Assumes: pin idles high through its pull-up
// Notes:   busy covers the low pulse plus resync time
module aux_ctrl_model (
    input  wire logic       clk,
    input  wire logic       clear_req,
    input  wire logic [7:0] low_cycles,
    output logic            aux_reset_n,
    output logic            busy
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        aux_reset_n = 1'b1;
        busy = 1'b0;
    end
    // Bench removes the fault source before raising clear_req, except t_error, which holds error_cause bit 0 through one clear
    always @(posedge clk) begin
        if (clear_req && !busy) begin
            busy <= 1'b1;
            aux_reset_n <= 1'b0;
            repeat (low_cycles) @(posedge clk);
            aux_reset_n <= 1'b1;
            repeat (4) @(posedge clk);
            busy <= 1'b0;
        end
    end
endmodule

//--- dv/compensator_fault_status_manager_tb.sv
// Purpose: self-checking bench of the fault status manager
// Assumes: debounce shortened to 4 cycles
// Notes:   inputs change 1 ns after the rising edge
`include "fault_consts.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module compensator_fault_status_manager_tb
    import fault_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, aux_reset_n, clear_req, busy;
    logic config_mode, advanced_mode, linear_mode, integrity_fail, warning_cause;
    logic awaiting_reference, injecting_pulses, algorithm_failed, ref_strobe, enc_step, enc_down;
    logic [`ERR_SRC_COUNT-1:0] error_cause, error_cause_latched;
    sensor_vec_t sensor_failed, sensor_allocated, sensor_active_role, sensor_fail_report;
    comp_t enc_comp, wp_comp, struct_comp;
    temp_t live_air_temp, air_temperature_reading;
    logic [1:0] table_index;
    logic critical_system_fault, error_out, suspend_out_n, warning_out_n;
    logic [2:0] severity_level, selected_parameter_table;
    count_t raw_encoder_count, compensated_output_count, total_compensation_applied;
    logic [7:0] low_cycles = 8'h0a;
    int miscompares = 0, checks = 0;
    compensator_fault_status_manager #(.DEBOUNCE_CYCLES(4))
        u_compensator_fault_status_manager (.*);
    aux_ctrl_model u_aux_ctrl_model (.clk(clk), .clear_req(clear_req), .low_cycles(low_cycles),
        .aux_reset_n(aux_reset_n), .busy(busy));
    always #5 clk = ~clk;
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic clear_pin();
        clear_req = 1'b1;
        step(1);
        clear_req = 1'b0;
        repeat (40) if (busy) step(1);
        step(3);
    endtask
    task automatic t_error();
        error_cause = 4'h2;
        step(1);
        error_cause = 4'h0;
        step(2);
        `CHK(error_out, 1'b1)
        `CHK(severity_level, 3'h2)
        error_cause = 4'h1;
        clear_pin();
        `CHK(error_cause_latched, 4'h1)
        error_cause = 4'h0;
        clear_pin();
        `CHK({error_out, error_cause_latched}, 5'h00)
    endtask
    // A low shorter than the debounce time must not clear anything
    task automatic t_short();
        error_cause = 4'h8;
        step(1);
        error_cause = 4'h0;
        low_cycles = 8'h02;
        clear_pin();
        `CHK(error_cause_latched, 4'h8)
        low_cycles = 8'h0a;
        clear_pin();
        `CHK(error_cause_latched, 4'h0)
    endtask
    task automatic t_susp();
        for (int i = 0; i < 3; i++) begin
            {awaiting_reference, injecting_pulses, algorithm_failed} = 3'h1 << i;
            step(2);
            `CHK(suspend_out_n, 1'b0)
            {awaiting_reference, injecting_pulses, algorithm_failed} = 3'h0;
            step(2);
            `CHK(suspend_out_n, 1'b1)
        end
    endtask
    task automatic t_warn();
        warning_cause = 1'b1;
        step(2);
        `CHK({warning_out_n, severity_level}, 4'h3)
        warning_cause = 1'b0;
        sensor_failed = 4'h4;
        sensor_allocated = 4'h6;
        step(2);
        `CHK({warning_out_n, error_out, severity_level}, 5'h14)
        `CHK(sensor_fail_report, 4'h4)
        advanced_mode = 1'b1;
        step(2);
        `CHK(warning_out_n, 1'b0)
        sensor_active_role = 4'h4;
        step(2);
        `CHK(error_out, 1'b1)
        {sensor_failed, sensor_active_role, advanced_mode} = '0;
        clear_pin();
        `CHK({error_out, warning_out_n}, 2'h1)
    endtask
    task automatic t_count();
        {enc_comp, wp_comp, struct_comp} = {24'h000010, 24'hfffffd, 24'h000001};
        enc_step = 1'b1;
        step(5);
        enc_down = 1'b1;
        step(2);
        enc_step = 1'b0;
        step(4);
        `CHK(raw_encoder_count, count_t'(3))
        `CHK(total_compensation_applied, count_t'(14))
        `CHK(compensated_output_count, count_t'(17))
        {ref_strobe, enc_step} = 2'h3;
        step(1);
        {ref_strobe, enc_step} = 2'h0;
        step(4);
        `CHK(raw_encoder_count, count_t'(0))
    endtask
    task automatic t_misc();
        linear_mode = 1'b1;
        live_air_temp = 16'h0123;
        step(2);
        `CHK(air_temperature_reading, `AIR_DEFAULT_DECI_C)
        linear_mode = 1'b0;
        config_mode = 1'b1;
        step(2);
        `CHK(air_temperature_reading, 16'h0123)
        `CHK(error_out, 1'b1)
        config_mode = 1'b0;
        for (int i = 0; i < 4; i++) begin
            table_index = i[1:0];
            step(2);
            `CHK(selected_parameter_table, 3'(i + 1))
        end
    endtask
    task automatic t_sys();
        integrity_fail = 1'b1;
        step(1);
        integrity_fail = 1'b0;
        step(1);
        clear_pin();
        `CHK({critical_system_fault, error_out, severity_level}, 5'h19)
        rst = 1'b1;
        step(1);
        rst = 1'b0;
        step(2);
        `CHK({critical_system_fault, error_out}, 2'h0)
    endtask
    task automatic print_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        {config_mode, advanced_mode, linear_mode, integrity_fail, warning_cause, clear_req} = '0;
        {awaiting_reference, injecting_pulses, algorithm_failed, ref_strobe, enc_step} = '0;
        {enc_down, error_cause, sensor_failed, sensor_allocated, sensor_active_role} = '0;
        {enc_comp, wp_comp, struct_comp, live_air_temp, table_index} = '0;
        step(10);
        rst = 1'b0;
        step(2);
        `CHK({suspend_out_n, warning_out_n, selected_parameter_table}, 5'h19)
        t_error();
        t_short();
        t_susp();
        t_warn();
        t_count();
        t_misc();
        t_sys();
        print_verdict();
    end
    // Whole run is under two hundred cycles
    initial begin
        #100us;
        miscompares++;
        print_verdict();
    end
endmodule
bind compensator_fault_status_manager fault_props u_fault_props (.*);

//--- dv/fault_props.sv
// Purpose: port-level checks of the fault status manager
// Assumes: rst is synchronous, outputs follow inputs one edge later, total compensation two edges later
// Notes:   role-based sensor escalation left to the bench
`include "fault_consts.svh"
module fault_props
    import fault_pkg::*;
(
    input wire logic                      clk,
    input wire logic                      rst,
    input wire logic                      integrity_fail,
    input wire logic [`ERR_SRC_COUNT-1:0] error_cause,
    input wire logic                      awaiting_reference,
    input wire logic                      injecting_pulses,
    input wire logic                      algorithm_failed,
    input wire logic                      warning_cause,
    input wire logic                      advanced_mode,
    input wire logic                      config_mode,
    input wire logic                      linear_mode,
    input wire sensor_vec_t               sensor_failed,
    input wire sensor_vec_t               sensor_allocated,
    input wire logic [1:0]                table_index,
    input wire comp_t                     enc_comp,
    input wire comp_t                     wp_comp,
    input wire comp_t                     struct_comp,
    input wire logic                      critical_system_fault,
    input wire logic                      error_out,
    input wire logic                      suspend_out_n,
    input wire logic                      warning_out_n,
    input wire logic [2:0]                severity_level,
    input wire sensor_vec_t               sensor_fail_report,
    input wire logic [`ERR_SRC_COUNT-1:0] error_cause_latched,
    input wire count_t                    total_compensation_applied,
    input wire temp_t                     air_temperature_reading,
    input wire logic [2:0]                selected_parameter_table
);
    timeunit 1ns;
    timeprecision 1ps;
    logic   susp_any;
    count_t csum;
    assign susp_any = awaiting_reference | injecting_pulses | algorithm_failed;
    // Widen before adding so the sum cannot wrap at the term width
    assign csum = count_t'(enc_comp) + count_t'(wp_comp) + count_t'(struct_comp);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_sys_sticky: assert property (critical_system_fault |=>
        critical_system_fault && error_out)
        else $error("system fault dropped without power-on reset");
    a_sys_level: assert property (integrity_fail |=>
        critical_system_fault && severity_level == 3'h1)
        else $error("system fault not raised at top severity");
    a_err_latch: assert property (error_cause != 4'h0 |=> error_out &&
        ((error_cause_latched & $past(error_cause)) == $past(error_cause)))
        else $error("error source not latched");
    a_susp_set: assert property (susp_any |=> !suspend_out_n)
        else $error("suspend not asserted");
    a_susp_drop: assert property (!susp_any |=> suspend_out_n)
        else $error("suspend held without cause");
    a_warn_drop: assert property (!warning_cause && !advanced_mode |=> warning_out_n)
        else $error("warning held without cause");
    a_warn_low: assert property (warning_cause |=> !warning_out_n)
        else $error("warning not driven low");
    a_sensor_warn: assert property (advanced_mode && (sensor_failed & sensor_allocated) != 4'h0
        |=> !warning_out_n)
        else $error("sensor failure gave no warning");
    a_cfg_error: assert property (config_mode |=> error_out)
        else $error("error output low in configuration mode");
    a_air_fixed: assert property (linear_mode |=>
        air_temperature_reading == `AIR_DEFAULT_DECI_C)
        else $error("air reading not fixed in linear mode");
    a_sensor_report: assert property (1'b1 |=> sensor_fail_report ==
        $past(sensor_failed & sensor_allocated))
        else $error("sensor report wrong");
    a_table_sel: assert property (1'b1 |=> selected_parameter_table ==
        {1'b0, $past(table_index)} + 3'h1)
        else $error("table index wrong");
    a_comp_sum: assert property (!$past(rst) |=>
        total_compensation_applied == $past(csum, 2))
        else $error("total compensation wrong");
    cover property (integrity_fail);
    cover property (error_out ##1 !error_out);
    cover property (!suspend_out_n ##1 suspend_out_n);
endmodule

//--- src/compensator_fault_status_manager.sv
// Purpose: fault severity sorting and auxiliary status lines for one axis
// Assumes: rst is the power-on reset; fault inputs come from logic on clk
// Notes:   only aux_reset_n is a pin and is synchronised in the helper
`include "fault_consts.svh"
module compensator_fault_status_manager
    import fault_pkg::*;
#(
    parameter int unsigned DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES
) (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      aux_reset_n,
    input  wire logic                      config_mode,
    input  wire logic                      advanced_mode,
    input  wire logic                      linear_mode,
    input  wire logic                      integrity_fail,
    input  wire logic [`ERR_SRC_COUNT-1:0] error_cause,
    input  wire logic                      awaiting_reference,
    input  wire logic                      injecting_pulses,
    input  wire logic                      algorithm_failed,
    input  wire logic                      warning_cause,
    input  wire sensor_vec_t               sensor_failed,
    input  wire sensor_vec_t               sensor_allocated,
    input  wire sensor_vec_t               sensor_active_role,
    input  wire logic                      ref_strobe,
    input  wire logic                      enc_step,
    input  wire logic                      enc_down,
    input  wire comp_t                     enc_comp,
    input  wire comp_t                     wp_comp,
    input  wire comp_t                     struct_comp,
    input  wire temp_t                     live_air_temp,
    input  wire logic [1:0]                table_index,
    output logic                           critical_system_fault,
    output logic                           error_out,
    output logic                           suspend_out_n,
    output logic                           warning_out_n,
    output logic [2:0]                     severity_level,
    output sensor_vec_t                    sensor_fail_report,
    output logic [`ERR_SRC_COUNT-1:0]      error_cause_latched,
    output count_t                         raw_encoder_count,
    output count_t                         compensated_output_count,
    output count_t                         total_compensation_applied,
    output temp_t                          air_temperature_reading,
    output logic [2:0]                     selected_parameter_table
);
    fault_if link ();

    reset_debounce #(
        .DEBOUNCE_CYCLES (DEBOUNCE_CYCLES)
    ) u_debounce (
        .clk         (clk),
        .rst         (rst),
        .aux_reset_n (aux_reset_n),
        .bus         (link.deb)
    );

    count_tracker u_counts (
        .clk         (clk),
        .rst         (rst),
        .ref_strobe  (ref_strobe),
        .enc_step    (enc_step),
        .enc_down    (enc_down),
        .enc_comp    (enc_comp),
        .wp_comp     (wp_comp),
        .struct_comp (struct_comp),
        .bus         (link.cnt)
    );

    typedef struct packed {
        logic                      sys_fault;
        logic [`ERR_SRC_COUNT-1:0] err_latch;
        logic                      sensor_err_latch;
        logic                      error_line;
        logic                      suspend_n;
        logic                      warning_n;
        sev_t                      severity;
        sensor_vec_t               sensor_report;
        count_t                    raw;
        count_t                    out;
        count_t                    comp;
        temp_t                     air;
        logic [2:0]                table_sel;
    } core_t;

    core_t s_q, s_d;

    // Failures of sensors this unit has allocated
    sensor_vec_t seen_fail;
    // Failures that sit on sensors with an active compensation role
    sensor_vec_t role_fail;

    genvar gi;
    generate
        for (gi = 0; gi < `SENSOR_COUNT; gi++) begin : g_sensor
            assign seen_fail[gi] = sensor_failed[gi] & sensor_allocated[gi];
            assign role_fail[gi] = seen_fail[gi] & sensor_active_role[gi];
        end
    endgenerate

    logic any_sensor_fail;
    logic any_role_fail;
    logic suspend_cause;
    logic warn_now;

    assign any_sensor_fail = |seen_fail;
    assign any_role_fail   = |role_fail;
    assign suspend_cause   = awaiting_reference | injecting_pulses | algorithm_failed;
    assign warn_now        = warning_cause | (advanced_mode & any_sensor_fail);

    always_comb begin
        s_d = s_q;

        // Nothing but rst clears this flag; the pin path never touches it
        if (integrity_fail) begin
            s_d.sys_fault = 1'b1;
        end

        // Clear only sources whose cause is gone; a new event wins over the clear
        for (int i = 0; i < `ERR_SRC_COUNT; i++) begin
            if (error_cause[i]) begin
                s_d.err_latch[i] = 1'b1;
            end else if (link.clear_pulse) begin
                s_d.err_latch[i] = 1'b0;
            end
        end

        if (any_role_fail) begin
            s_d.sensor_err_latch = 1'b1;
        end else if (link.clear_pulse) begin
            s_d.sensor_err_latch = 1'b0;
        end

        // System fault drives error too, and the clear pulse cannot drop it
        s_d.error_line = s_d.sys_fault | (|s_d.err_latch) | s_d.sensor_err_latch
                         | config_mode;

        // Both lines are live levels, never latched
        s_d.suspend_n = ~suspend_cause;
        s_d.warning_n = ~warn_now;

        // Report the most severe level present
        if (s_d.sys_fault) begin
            s_d.severity = SEV_SYSTEM;
        end else if ((|s_d.err_latch) | s_d.sensor_err_latch) begin
            s_d.severity = SEV_ERROR;
        end else if (warning_cause) begin
            s_d.severity = SEV_WARNING;
        end else if (any_sensor_fail) begin
            s_d.severity = SEV_SENSOR;
        end else begin
            s_d.severity = SEV_NONE;
        end

        s_d.sensor_report = seen_fail;

        s_d.raw  = link.raw_count;
        s_d.out  = link.out_count;
        s_d.comp = link.comp_sum;

        // Linear scales have no refractive index path, so no live air sensor
        s_d.air = linear_mode ? `AIR_DEFAULT_DECI_C : live_air_temp;

        // Index 0..3 reports as table 1..4
        s_d.table_sel = `TABLE_FIRST + {1'b0, table_index};
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q.sys_fault        <= 1'b0;
            s_q.err_latch        <= '0;
            s_q.sensor_err_latch <= 1'b0;
            s_q.error_line       <= 1'b0;
            s_q.suspend_n        <= 1'b1;
            s_q.warning_n        <= 1'b1;
            s_q.severity         <= SEV_NONE;
            s_q.sensor_report    <= '0;
            s_q.raw              <= '0;
            s_q.out              <= '0;
            s_q.comp             <= '0;
            s_q.air              <= `AIR_DEFAULT_DECI_C;
            s_q.table_sel        <= `TABLE_FIRST;
        end else begin
            s_q <= s_d;
        end
    end

    assign critical_system_fault      = s_q.sys_fault;
    assign error_out                  = s_q.error_line;
    assign suspend_out_n              = s_q.suspend_n;
    assign warning_out_n              = s_q.warning_n;
    assign severity_level             = s_q.severity;
    assign sensor_fail_report         = s_q.sensor_report;
    assign error_cause_latched        = s_q.err_latch;
    assign raw_encoder_count          = s_q.raw;
    assign compensated_output_count   = s_q.out;
    assign total_compensation_applied = s_q.comp;
    assign air_temperature_reading    = s_q.air;
    assign selected_parameter_table   = s_q.table_sel;
endmodule

//--- src/count_tracker.sv
// Purpose: raw and compensated position counts, total compensation
// Assumes: step inputs are one-cycle pulses on clk
// Notes:   counts wrap in two's complement
`include "fault_consts.svh"
module count_tracker
    import fault_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ref_strobe,
    input  wire logic enc_step,
    input  wire logic enc_down,
    input  comp_t     enc_comp,
    input  comp_t     wp_comp,
    input  comp_t     struct_comp,
    fault_if.cnt      bus
);
    typedef struct packed {
        count_t raw;
        count_t sum;
        count_t out;
    } ct_t;

    ct_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        if (ref_strobe) begin
            s_d.raw = '0;
        end else if (enc_step) begin
            s_d.raw = enc_down ? count_t'(s_q.raw - 1) : count_t'(s_q.raw + 1);
        end
        s_d.sum = count_t'(enc_comp) + count_t'(wp_comp) + count_t'(struct_comp);
        s_d.out = count_t'(s_q.raw + s_q.sum);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.raw_count = s_q.raw;
    assign bus.comp_sum  = s_q.sum;
    assign bus.out_count = s_q.out;
endmodule

//--- src/reset_debounce.sv
// Purpose: synchronise and debounce the active-low auxiliary reset pin
// Assumes: pin is asynchronous to clk
// Notes:   one clear pulse per accepted low level
`include "fault_consts.svh"
module reset_debounce
    import fault_pkg::*;
#(
    parameter int unsigned DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic aux_reset_n,
    fault_if.deb      bus
);
    typedef struct packed {
        logic        sync1;
        logic        sync2;
        db_state_t   state;
        logic [31:0] cnt;
        logic        pulse;
    } db_t;

    db_t s_q, s_d;

    always_comb begin
        s_d       = s_q;
        s_d.sync1 = aux_reset_n;
        s_d.sync2 = s_q.sync1;
        s_d.pulse = 1'b0;
        case (s_q.state)
            DB_IDLE: begin
                s_d.cnt = 32'h0;
                if (!s_q.sync2) begin
                    s_d.state = DB_LOW_WAIT;
                end
            end
            DB_LOW_WAIT: begin
                if (s_q.sync2) begin
                    s_d.state = DB_IDLE;
                end else if (s_q.cnt >= DEBOUNCE_CYCLES - 1) begin
                    s_d.state = DB_HELD;
                    s_d.pulse = 1'b1;
                end else begin
                    s_d.cnt = s_q.cnt + 32'h1;
                end
            end
            DB_HELD: begin
                // Held low gives no further pulses; release must be seen first
                if (s_q.sync2) begin
                    s_d.state = DB_IDLE;
                end
            end
            default: s_d.state = DB_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '{sync1: 1'b1, sync2: 1'b1, state: DB_IDLE, cnt: 32'h0,
                     pulse: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.clear_pulse = s_q.pulse;
endmodule
